// ===== bench/dcl_ctrl_tb_top.sv
// self-checking bench for the device command layer controller
`default_nettype none
`include "dcl_defines.svh"
module dcl_ctrl_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import dcl_pkg::*;
  logic clk, rst, hard, tx_done, dpass, q_rdy, pdone, slow;
  logic psel, penable, pwrite, pready, pslverr, go, abort, dset, abq, hw_init;
  logic [7:0] paddr;
  logic [4:0] q_tag;
  logic [31:0] pwdata, prdata, sig, r;
  dcl_rx_frame_s rx;
  dcl_tx_req_s tx;
  dcl_queued_e q_kind;
  dcl_proto_e proto;
  dcl_state_e state;
  int errors, checked, go_n, ds_n, aq_n, td_n;
  dcl_ctrl #(.QUEUING(1'b1), .DIAG_CYCLES(4)) dcl_ctrl_i (.i_clk(clk), .i_reset(rst), .i_hard_reset(hard),
    .i_rx(rx), .i_tx_done(tx_done), .i_diag_pass(dpass), .i_queue_ready(q_rdy), .i_queue_kind(q_kind),
    .i_queue_tag(q_tag), .i_proto_done(pdone), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .o_tx(tx),
    .o_proto(proto), .o_proto_go(go), .o_proto_abort(abort), .o_dma_setup_seen(dset),
    .o_abort_queue(abq), .o_hw_init(hw_init), .o_signature(sig), .o_state(state));
  dcl_xport_model dcl_xport_model_i (.i_clk(clk), .i_reset(rst), .i_tx(tx), .i_slow(slow), .o_tx_done(tx_done));
  // clock and pulse counters
  always #12.5 clk = ~clk;
  always @(posedge clk) begin
    go_n <= go_n + (go === 1'b1);
    ds_n <= ds_n + (dset === 1'b1);
    aq_n <= aq_n + (abq === 1'b1);
    td_n <= td_n + (tx_done === 1'b1);
  end
  task automatic close_out;
    $display("checks %0d errors %0d", checked, errors);
    if (errors == 0 && checked > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : close_out
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    checked++;
    if (s !== e) begin
      errors++;
      $display("BAD t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask : chk
  task automatic wst(input dcl_state_e st);
    int n;
    n = 0;
    while (state !== st && n < 80) begin
      @(posedge clk); #1;
      n++;
    end
    chk(32'(state), 32'(st));
  endtask : wst
  task automatic wgo(input int g0);
    int n;
    n = 0;
    while (go_n == g0 && n < 40) begin
      @(posedge clk); #1;
      n++;
    end
    chk(32'(go_n != g0), 32'h1);
  endtask : wgo
  task automatic frm(input logic [7:0] ft, input logic c, input logic sr, input dcl_cmd_class_e cl);
    @(posedge clk);
    rx <= '{1'b1, ft, c, {5'h00, sr, 2'h0}, cl};
    @(posedge clk);
    rx.valid <= 1'b0;
  endtask : frm
  task automatic nxt(input logic [7:0] ft, input logic c, input logic sr, input dcl_cmd_class_e cl,
                     input dcl_state_e ex);
    frm(ft, c, sr, cl);
    #1 chk(32'(state), 32'(frame_check_state));
    @(posedge clk); #1;
    chk(32'(state), 32'(ex));
  endtask : nxt
  task automatic done_p;
    @(posedge clk) pdone <= 1'b1;
    @(posedge clk) pdone <= 1'b0;
    wst(idle_state);
  endtask : done_p
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    {psel, pwrite, paddr, pwdata} <= {1'b1, w, a, d};
    @(posedge clk) penable <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    chk(32'(pready), 32'h1);
    r = prdata;
    chk(32'(pslverr), 32'h0);
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic t_hreset(input logic pass);
    @(posedge clk);
    hard  <= 1'b1;
    dpass <= pass;
    @(posedge clk); #1;
    chk(32'(state), 32'(hard_reset_wait_state));
    chk(32'(abort), 32'h1);
    repeat (3) @(posedge clk);
    #1 chk(32'(state), 32'(hard_reset_wait_state));
    @(posedge clk) hard <= 1'b0;
    wst(hard_reset_diag_state);
    wst(pass ? hard_reset_good_state : hard_reset_bad_state);
    @(posedge clk); #1;
    chk(32'(tx.valid), 32'h1);
    chk(32'(tx.fis_type), 32'(`DCL_FIS_REG_D2H));
    chk(sig, `DCL_SIG_RESET);
    wst(idle_state);
    apb(1'b0, `DCL_REG_DIAG_RESULT, 32'h0);
    chk(r, 32'(!pass));
    $display("hard reset test done");
  endtask : t_hreset
  task automatic t_frames;
    int d0;
    d0 = ds_n;
    nxt(`DCL_FIS_REG_H2D, 1'b0, 1'b0, dcl_c_non_data, idle_state);
    nxt(`DCL_FIS_DMA_SETUP, 1'b0, 1'b0, dcl_c_non_data, idle_state);
    repeat (2) @(posedge clk);
    chk(ds_n, d0 + 1);
    nxt(8'h46, 1'b1, 1'b1, dcl_c_non_data, idle_state);
    chk(ds_n, d0 + 1);
    $display("frame test done");
  endtask : t_frames
  task automatic t_cmd(input dcl_cmd_class_e cl, input logic [4:0] ex);
    int g0;
    g0 = go_n;
    nxt(`DCL_FIS_REG_H2D, 1'b1, 1'b0, cl, command_check_state);
    wgo(g0);
    chk(32'(proto), 32'(ex));
    done_p();
    $display("command test done");
  endtask : t_cmd
  task automatic t_unimpl;
    int a0;
    a0 = aq_n;
    slow <= 1'b1;
    nxt(`DCL_FIS_REG_H2D, 1'b1, 1'b0, dcl_c_unimpl, command_check_state);
    wst(no_command_state);
    @(posedge clk); #1;
    chk(aq_n, a0 + 1);
    chk(32'({tx.valid, tx.fis_type, tx.i_flag}), 32'({1'b1, `DCL_FIS_REG_D2H, 1'b1}));
    wst(idle_state);
    slow <= 1'b0;
    $display("no-command test done");
  endtask : t_unimpl
  task automatic t_setserv;
    @(posedge clk) q_rdy <= 1'b1;
    wst(set_service_state);
    q_rdy <= 1'b0;
    @(posedge clk); #1;
    chk(32'({tx.fis_type, tx.status[`DCL_STATUS_SERV_BIT], tx.i_flag}), 32'({`DCL_FIS_SET_DEV_BITS, 2'b11}));
    wst(idle_state);
    $display("set-service test done");
  endtask : t_setserv
  task automatic t_serv(input int k);
    int g0, t0;
    g0 = go_n;
    t0 = td_n;
    q_kind <= dcl_queued_e'(k);
    q_tag  <= 5'h11 + 5'(k);
    nxt(`DCL_FIS_REG_H2D, 1'b1, 1'b0, dcl_c_service, command_check_state);
    wst(service_test_state);
    if (k >= 2) begin
      wst(tag_send_state);
      @(posedge clk); #1;
      chk(32'(tx.tag), 32'(5'h11 + 5'(k)));
    end
    wst(service_decode_state);
    chk(td_n, t0 + (k >= 2));
    wgo(g0);
    chk(32'(proto), 32'(5'h0c + 5'(k)));
    done_p();
    $display("service test done");
  endtask : t_serv
  task automatic t_soft;
    int g0;
    t_cmd(dcl_c_pio_in, 5'(dcl_p_pio_in));
    nxt(`DCL_FIS_REG_H2D, 1'b1, 1'b0, dcl_c_pio_out, command_check_state);
    frm(`DCL_FIS_REG_H2D, 1'b0, 1'b1, dcl_c_non_data);
    wst(soft_reset_asserted_state);
    frm(`DCL_FIS_REG_H2D, 1'b1, 1'b0, dcl_c_non_data);
    repeat (8) @(posedge clk);
    #1 chk(32'(state), 32'(soft_reset_asserted_state));
    chk(32'(hw_init), 32'h1);
    g0 = go_n;
    frm(`DCL_FIS_REG_H2D, 1'b0, 1'b0, dcl_c_non_data);
    wgo(g0);
    chk(32'(proto), 32'(dcl_p_soft_rst));
    done_p();
    $display("soft reset test done");
  endtask : t_soft
  task automatic t_both;
    nxt(`DCL_FIS_REG_H2D, 1'b1, 1'b0, dcl_c_dma_in, command_check_state);
    @(posedge clk);
    hard <= 1'b1;
    rx   <= '{1'b1, `DCL_FIS_REG_H2D, 1'b0, 8'h04, dcl_c_non_data};
    @(posedge clk) rx.valid <= 1'b0;
    #1 chk(32'(state), 32'(hard_reset_wait_state));
    t_hreset(1'b1);
    $display("reset priority test done");
  endtask : t_both
  task automatic t_regs;
    apb(1'b0, `DCL_REG_STATUS, 32'h0);
    chk(32'(r[12:8]), 32'(idle_state));
    apb(1'b0, `DCL_REG_SIGNATURE, 32'h0);
    chk(r, `DCL_SIG_RESET);
    apb(1'b1, `DCL_REG_CONTROL, 32'h0);
    apb(1'b0, `DCL_REG_CONTROL, 32'h0);
    chk(r, 32'h0);
    apb(1'b1, `DCL_REG_CONTROL, `DCL_CTRL_RESET);
    apb(1'b0, 8'h20, 32'h0);
    chk(r, 32'h0);
    $display("register test done");
  endtask : t_regs
  // main sequence
  initial begin
    {clk, hard, tx_done, q_rdy, pdone, slow, psel, penable, pwrite} = '0;
    {paddr, pwdata, q_tag, errors, checked, go_n, ds_n, aq_n, td_n} = '0;
    rx     = '0;
    q_kind = dcl_q_pio_in;
    dpass  = 1'b1;
    rst    = 1'b1;
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    wst(idle_state);
    apb(1'b0, `DCL_REG_CONTROL, 32'h0);
    chk(r, `DCL_CTRL_RESET);
    t_regs();
    t_frames();
    for (int i = 1; i <= 10; i++) t_cmd(dcl_cmd_class_e'(i), 5'(i));
    t_unimpl();
    t_setserv();
    for (int k = 0; k < 6; k++) t_serv(k);
    t_hreset(1'b0);
    t_cmd(dcl_c_non_data, 5'(dcl_p_non_data));
    nxt(`DCL_FIS_REG_H2D, 1'b1, 1'b0, dcl_c_packet, command_check_state);
    t_hreset(1'b1);
    t_soft();
    t_both();
    close_out();
  end
  // watchdog
  initial begin
    #800000;
    errors++;
    close_out();
  end
endmodule : dcl_ctrl_tb_top
`default_nettype wire

// ===== bench/dcl_xport_model.sv
// transport layer model: answers each frame request after a prompt or slow delay
`default_nettype none
module dcl_xport_model (
  input  wire logic                 i_clk,
  input  wire logic                 i_reset,
  input  wire dcl_pkg::dcl_tx_req_s i_tx,
  input  wire logic                 i_slow,
  output logic                      o_tx_done
);
  timeunit 1ns;
  timeprecision 1ps;
  import dcl_pkg::*;
  logic [3:0] cnt_q;
  // count out the send time, then pulse done once per request
  always_ff @(posedge i_clk) begin
    o_tx_done <= 1'b0;
    if (i_reset || !i_tx.valid || o_tx_done) begin
      cnt_q <= 4'h0;
    end else if (cnt_q >= (i_slow ? 4'h6 : 4'h1)) begin
      o_tx_done <= 1'b1;
      cnt_q     <= 4'h0;
    end else begin
      cnt_q <= cnt_q + 4'h1;
    end
  end
endmodule : dcl_xport_model
`default_nettype wire

// ===== hw/dcl_ctrl.sv
// device command layer: reset protocols, idle and service dispatch
`default_nettype none
`include "dcl_defines.svh"
module dcl_ctrl #(
  parameter bit          QUEUING     = 1'b1,
  parameter int unsigned DIAG_CYCLES = `DCL_DIAG_CYCLES
) (
  input  wire logic                  i_clk,
  input  wire logic                  i_reset,
  input  wire logic                  i_hard_reset,
  input  wire dcl_pkg::dcl_rx_frame_s i_rx,
  input  wire logic                  i_tx_done,
  input  wire logic                  i_diag_pass,
  input  wire logic                  i_queue_ready,
  input  wire dcl_pkg::dcl_queued_e  i_queue_kind,
  input  wire logic [4:0]            i_queue_tag,
  input  wire logic                  i_proto_done,
  input  wire logic                  psel,
  input  wire logic                  penable,
  input  wire logic                  pwrite,
  input  wire logic [7:0]            paddr,
  input  wire logic [31:0]           pwdata,
  output logic [31:0]                prdata,
  output logic                       pready,
  output logic                       pslverr,
  output dcl_pkg::dcl_tx_req_s       o_tx,
  output dcl_pkg::dcl_proto_e        o_proto,
  output logic                       o_proto_go,
  output logic                       o_proto_abort,
  output logic                       o_dma_setup_seen,
  output logic                       o_abort_queue,
  output logic                       o_hw_init,
  output logic [31:0]                o_signature,
  output dcl_pkg::dcl_state_e        o_state
);
  import dcl_pkg::*;

  dcl_regs_s q;
  dcl_regs_s d;
  logic      srst_req;
  logic      in_proto;
  logic      apb_acc;
  logic      diag_done;

  // soft reset request seen in a register frame without command flag
  assign srst_req  = i_rx.valid && i_rx.fis_type == `DCL_FIS_REG_H2D && !i_rx.c_flag
                     && i_rx.devctl[`DCL_DEVCTL_SRST_BIT];
  assign in_proto  = q.state != idle_state && q.state != soft_reset_asserted_state;
  assign apb_acc   = psel && penable && !q.pready;
  assign diag_done = q.diag_cnt >= 16'(DIAG_CYCLES - 1);

  // -----------------------------------------------------------------
  // next state
  // -----------------------------------------------------------------
  always_comb begin
    d               = q;
    d.tx.valid      = 1'b0;
    d.proto_go      = 1'b0;
    d.dma_setup_seen = 1'b0;
    d.abort_queue   = 1'b0;
    d.pready        = 1'b0;
    unique case (q.state)
      hard_reset_wait_state: begin
        d.diag_cnt = 16'h0000;
        if (!i_hard_reset) begin
          d.state = hard_reset_diag_state;
        end
      end
      hard_reset_diag_state, soft_reset_asserted_state: begin
        d.hw_init  = 1'b1;
        if (!diag_done) begin
          d.diag_cnt = q.diag_cnt + 16'h0001;
        end
        if (q.state == soft_reset_asserted_state) begin
          if (i_rx.valid && i_rx.fis_type == `DCL_FIS_REG_H2D && !i_rx.c_flag
              && !i_rx.devctl[`DCL_DEVCTL_SRST_BIT] && diag_done) begin
            d.hw_init = 1'b0;
            d.proto   = dcl_p_soft_rst;
            d.proto_go = 1'b1;
            d.state   = proto_dispatch_state;
          end
        end else if (diag_done) begin
          d.hw_init   = 1'b0;
          d.diag_fail = !i_diag_pass;
          d.state     = i_diag_pass ? hard_reset_good_state : hard_reset_bad_state;
        end
      end
      hard_reset_good_state, hard_reset_bad_state: begin
        d.signature            = `DCL_SIG_RESET;
        d.status               = 8'h00;
        d.status[`DCL_STATUS_DRDY_BIT] = (q.state == hard_reset_good_state);
        d.status[`DCL_STATUS_ERR_BIT]  = (q.state == hard_reset_bad_state);
        d.error                = (q.state == hard_reset_good_state) ? 8'h01 : 8'h00;
        d.tx.valid             = !i_tx_done;
        d.tx.fis_type          = `DCL_FIS_REG_D2H;
        d.tx.i_flag            = 1'b0;
        d.tx.status            = d.status;
        d.tx.error             = d.error;
        d.tx.tag               = 5'h00;
        if (i_tx_done) begin
          d.state = idle_state;
        end
      end
      idle_state: begin
        if (i_rx.valid) begin
          d.state = frame_check_state;
        end else if (QUEUING && i_queue_ready && q.control[0]) begin
          d.state = set_service_state;
        end
      end
      frame_check_state: begin
        d.state = idle_state;
        if (i_rx.fis_type == `DCL_FIS_REG_H2D) begin
          if (i_rx.c_flag) begin
            d.state = command_check_state;
          end else if (i_rx.devctl[`DCL_DEVCTL_SRST_BIT]) begin
            d.state    = soft_reset_asserted_state;
            d.diag_cnt = 16'h0000;
          end
        end else if (i_rx.fis_type == `DCL_FIS_DMA_SETUP) begin
          d.dma_setup_seen = 1'b1;
        end
      end
      command_check_state: begin
        d.proto_go = 1'b1;
        d.state    = proto_dispatch_state;
        unique case (i_rx.cmd_class)
          dcl_c_non_data:  d.proto = dcl_p_non_data;
          dcl_c_pio_in:    d.proto = dcl_p_pio_in;
          dcl_c_pio_out:   d.proto = dcl_p_pio_out;
          dcl_c_dma_in:    d.proto = dcl_p_dma_in;
          dcl_c_dma_out:   d.proto = dcl_p_dma_out;
          dcl_c_packet:    d.proto = dcl_p_packet;
          dcl_c_dmaq_in:   d.proto = dcl_p_dmaq_in;
          dcl_c_dmaq_out:  d.proto = dcl_p_dmaq_out;
          dcl_c_exec_diag: d.proto = dcl_p_exec_diag;
          dcl_c_dev_reset: d.proto = dcl_p_dev_reset;
          dcl_c_service: begin
            d.proto_go = 1'b0;
            d.state    = QUEUING ? service_test_state : no_command_state;
            d.abort_queue = !QUEUING;
          end
          default: begin
            d.proto_go    = 1'b0;
            d.state       = no_command_state;
            d.abort_queue = 1'b1;
          end
        endcase
      end
      no_command_state: begin
        d.status[`DCL_STATUS_ERR_BIT] = 1'b1;
        d.error       = 8'h04; // abort bit
        d.tx.valid    = !i_tx_done;
        d.tx.fis_type = `DCL_FIS_REG_D2H;
        d.tx.i_flag   = 1'b1;
        d.tx.status   = d.status;
        d.tx.error    = d.error;
        d.tx.tag      = 5'h00;
        if (i_tx_done) begin
          d.state = idle_state;
        end
      end
      set_service_state: begin
        d.tx.valid    = !i_tx_done;
        d.tx.fis_type = `DCL_FIS_SET_DEV_BITS;
        d.tx.i_flag   = 1'b1;
        d.tx.status   = q.status | (8'h01 << `DCL_STATUS_SERV_BIT);
        d.tx.error    = q.error;
        d.tx.tag      = 5'h00;
        if (i_tx_done) begin
          d.state = idle_state;
        end
      end
      service_test_state: begin
        if (i_queue_kind == dcl_q_pio_in || i_queue_kind == dcl_q_pio_out) begin
          d.state = service_decode_state;
        end else begin
          d.state = tag_send_state;
        end
      end
      tag_send_state: begin
        d.tx.valid    = !i_tx_done;
        d.tx.fis_type = `DCL_FIS_REG_D2H;
        d.tx.i_flag   = 1'b0;
        d.tx.status   = q.status;
        d.tx.error    = q.error;
        d.tx.tag      = i_queue_tag;
        if (i_tx_done) begin
          d.state = service_decode_state;
        end
      end
      service_decode_state: begin
        d.proto_go = 1'b1;
        d.state    = proto_dispatch_state;
        unique case (i_queue_kind)
          dcl_q_pio_in:  d.proto = dcl_p_pkt_pio_in;
          dcl_q_pio_out: d.proto = dcl_p_pkt_pio_out;
          dcl_q_dma_in:  d.proto = dcl_p_pkt_dma_in;
          dcl_q_dma_out: d.proto = dcl_p_pkt_dma_out;
          dcl_q_dmaq_rd: d.proto = dcl_p_dmaq_send;
          dcl_q_dmaq_wr: d.proto = dcl_p_dmaq_act;
          default:       d.proto = dcl_p_none;
        endcase
      end
      proto_dispatch_state: begin
        if (i_proto_done) begin
          d.state = idle_state;
          d.proto = dcl_p_none;
        end
      end
      default: d.state = hard_reset_wait_state;
    endcase
    // soft reset preempts a running protocol
    if (srst_req && in_proto && q.state != frame_check_state) begin
      d.state    = soft_reset_asserted_state;
      d.diag_cnt = 16'h0000;
      d.proto    = dcl_p_none;
      d.tx.valid = 1'b0;
      d.proto_go = 1'b0;
    end
    // hard reset overrides every state transition, including soft reset
    if (i_hard_reset) begin
      d.state    = hard_reset_wait_state;
      d.proto    = dcl_p_none;
      d.tx.valid = 1'b0;
      d.proto_go = 1'b0;
    end
    // apb slave, one wait state
    if (apb_acc) begin
      d.pready = 1'b1;
      d.prdata = 32'h0000_0000;
      unique case (paddr)
        `DCL_REG_STATUS:      d.prdata = {19'h0, q.state, q.status};
        `DCL_REG_CONTROL:     d.prdata = q.control;
        `DCL_REG_DIAG_RESULT: d.prdata = {31'h0, q.diag_fail};
        `DCL_REG_SIGNATURE:   d.prdata = q.signature;
        `DCL_REG_CMD:         d.prdata = {27'h0, q.proto};
        default:              d.prdata = 32'h0000_0000;
      endcase
    end
    // write lands on the edge that completes the access
    if (psel && penable && q.pready && pwrite && paddr == `DCL_REG_CONTROL) begin
      d.control = pwdata;
    end
  end

  // -----------------------------------------------------------------
  // state register
  // -----------------------------------------------------------------
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      q         <= '0;
      q.state   <= hard_reset_wait_state;
      q.control <= `DCL_CTRL_RESET;
      q.proto   <= dcl_p_none;
    end else begin
      q <= d;
    end
  end

  assign prdata           = q.prdata;
  assign pready           = q.pready;
  assign pslverr          = 1'b0;
  assign o_tx             = q.tx;
  assign o_proto          = q.proto;
  assign o_proto_go       = q.proto_go;
  assign o_proto_abort    = i_hard_reset || (srst_req && in_proto && q.state != frame_check_state);
  assign o_dma_setup_seen = q.dma_setup_seen;
  assign o_abort_queue    = q.abort_queue;
  assign o_hw_init        = q.hw_init;
  assign o_signature      = q.signature;
  assign o_state          = q.state;

  // -----------------------------------------------------------------
  // checks
  // -----------------------------------------------------------------
  property p_hard_reset;
    @(posedge i_clk) disable iff (i_reset) i_hard_reset |=> q.state == hard_reset_wait_state;
  endproperty
  a_hard_reset: assert property (p_hard_reset) else $error("hard reset not taken");

  property p_hold_wait;
    @(posedge i_clk) disable iff (i_reset)
      q.state == hard_reset_wait_state && !i_hard_reset |=> q.state == hard_reset_diag_state;
  endproperty
  a_hold_wait: assert property (p_hold_wait) else $error("no diag after reset release");

  property p_idle_rx;
    @(posedge i_clk) disable iff (i_reset)
      q.state == idle_state && i_rx.valid && !i_hard_reset |=> q.state == frame_check_state;
  endproperty
  a_idle_rx: assert property (p_idle_rx) else $error("frame not checked");

  property p_reset_done;
    @(posedge i_clk) disable iff (i_reset)
      (q.state == hard_reset_good_state || q.state == hard_reset_bad_state) && i_tx_done
      && !i_hard_reset && !srst_req |=> q.state == idle_state;
  endproperty
  a_reset_done: assert property (p_reset_done) else $error("no idle after status");

  property p_dma_setup;
    @(posedge i_clk) disable iff (i_reset)
      q.state == frame_check_state && i_rx.fis_type == `DCL_FIS_DMA_SETUP && !i_hard_reset
      |=> o_dma_setup_seen && q.state == idle_state;
  endproperty
  a_dma_setup: assert property (p_dma_setup) else $error("dma setup not reported");

  property p_nocmd_abort;
    @(posedge i_clk) disable iff (i_reset)
      $rose(q.state == no_command_state) |-> o_abort_queue;
  endproperty
  a_nocmd_abort: assert property (p_nocmd_abort) else $error("queue not aborted");

  property p_serv_bit;
    @(posedge i_clk) disable iff (i_reset)
      o_tx.valid && o_tx.fis_type == `DCL_FIS_SET_DEV_BITS |-> o_tx.status[`DCL_STATUS_SERV_BIT] && o_tx.i_flag;
  endproperty
  a_serv_bit: assert property (p_serv_bit) else $error("service bit missing");

  property p_srst_enter;
    @(posedge i_clk) disable iff (i_reset)
      q.state == frame_check_state && i_rx.fis_type == `DCL_FIS_REG_H2D && !i_rx.c_flag
      && i_rx.devctl[`DCL_DEVCTL_SRST_BIT] && !i_hard_reset |=> q.state == soft_reset_asserted_state;
  endproperty
  a_srst_enter: assert property (p_srst_enter) else $error("soft reset not entered");

  property p_no_queue;
    @(posedge i_clk) disable iff (i_reset)
      !QUEUING |-> q.state != set_service_state && q.state != tag_send_state;
  endproperty
  a_no_queue: assert property (p_no_queue) else $error("service state without queuing");

  property p_nocmd_frame;
    @(posedge i_clk) disable iff (i_reset)
      q.state == no_command_state && o_tx.valid |-> o_tx.i_flag && o_tx.fis_type == `DCL_FIS_REG_D2H;
  endproperty
  a_nocmd_frame: assert property (p_nocmd_frame) else $error("no-command frame wrong");

  property p_serv_test;
    @(posedge i_clk) disable iff (i_reset)
      q.state == service_test_state && (i_queue_kind == dcl_q_pio_in || i_queue_kind == dcl_q_pio_out)
      && !i_hard_reset && !srst_req |=> q.state == service_decode_state;
  endproperty
  a_serv_test: assert property (p_serv_test) else $error("pio service not decoded");

  property p_tag_done;
    @(posedge i_clk) disable iff (i_reset)
      q.state == tag_send_state && i_tx_done && !i_hard_reset && !srst_req |=> q.state == service_decode_state;
  endproperty
  a_tag_done: assert property (p_tag_done) else $error("tag send not finished");
endmodule : dcl_ctrl
`default_nettype wire

// ===== hw/dcl_defines.svh
// timing counts, fis type codes and field positions for the device command layer
`ifndef DCL_DEFINES_SVH
`define DCL_DEFINES_SVH
`define DCL_FIS_REG_H2D        8'h27
`define DCL_FIS_REG_D2H        8'h34
`define DCL_FIS_DMA_SETUP      8'h41
`define DCL_FIS_SET_DEV_BITS   8'ha1
`define DCL_DEVCTL_SRST_BIT    2
`define DCL_STATUS_SERV_BIT    4
`define DCL_STATUS_ERR_BIT     0
`define DCL_STATUS_DRDY_BIT    6
`define DCL_DIAG_TIME_US       10
`define DCL_CLK_MHZ            40
`define DCL_DIAG_CYCLES        (`DCL_DIAG_TIME_US * `DCL_CLK_MHZ)
`define DCL_SIG_RESET          32'h0000_0101
`define DCL_REG_STATUS         8'h00
`define DCL_REG_CONTROL        8'h04
`define DCL_REG_DIAG_RESULT    8'h08
`define DCL_REG_SIGNATURE      8'h0c
`define DCL_REG_CMD            8'h10
`define DCL_CTRL_RESET         32'h0000_0001
`endif

// ===== hw/dcl_pkg.sv
// types shared by the device command layer
`default_nettype none
package dcl_pkg;
  typedef enum logic [4:0] {
    hard_reset_wait_state     = 5'h00,
    hard_reset_diag_state     = 5'h01,
    hard_reset_good_state     = 5'h02,
    hard_reset_bad_state      = 5'h03,
    idle_state                = 5'h04,
    frame_check_state         = 5'h05,
    command_check_state       = 5'h06,
    no_command_state          = 5'h07,
    set_service_state         = 5'h08,
    service_test_state        = 5'h09,
    tag_send_state            = 5'h0a,
    service_decode_state      = 5'h0b,
    soft_reset_asserted_state = 5'h0c,
    proto_dispatch_state      = 5'h0d
  } dcl_state_e;

  // protocol entry targets handed to the protocol bodies
  typedef enum logic [4:0] {
    dcl_p_none      = 5'h00,
    dcl_p_non_data  = 5'h01,
    dcl_p_pio_in    = 5'h02,
    dcl_p_pio_out   = 5'h03,
    dcl_p_dma_in    = 5'h04,
    dcl_p_dma_out   = 5'h05,
    dcl_p_packet    = 5'h06,
    dcl_p_dmaq_in   = 5'h07,
    dcl_p_dmaq_out  = 5'h08,
    dcl_p_exec_diag = 5'h09,
    dcl_p_dev_reset = 5'h0a,
    dcl_p_soft_rst  = 5'h0b,
    dcl_p_pkt_pio_in  = 5'h0c,
    dcl_p_pkt_pio_out = 5'h0d,
    dcl_p_pkt_dma_in  = 5'h0e,
    dcl_p_pkt_dma_out = 5'h0f,
    dcl_p_dmaq_send   = 5'h10,
    dcl_p_dmaq_act    = 5'h11
  } dcl_proto_e;

  // command classes reported by the command decoder
  typedef enum logic [3:0] {
    dcl_c_unimpl    = 4'h0,
    dcl_c_non_data  = 4'h1,
    dcl_c_pio_in    = 4'h2,
    dcl_c_pio_out   = 4'h3,
    dcl_c_dma_in    = 4'h4,
    dcl_c_dma_out   = 4'h5,
    dcl_c_packet    = 4'h6,
    dcl_c_dmaq_in   = 4'h7,
    dcl_c_dmaq_out  = 4'h8,
    dcl_c_exec_diag = 4'h9,
    dcl_c_dev_reset = 4'ha,
    dcl_c_service   = 4'hb
  } dcl_cmd_class_e;

  // kind of command waiting for service
  typedef enum logic [2:0] {
    dcl_q_pio_in  = 3'h0,
    dcl_q_pio_out = 3'h1,
    dcl_q_dma_in  = 3'h2,
    dcl_q_dma_out = 3'h3,
    dcl_q_dmaq_rd = 3'h4,
    dcl_q_dmaq_wr = 3'h5
  } dcl_queued_e;

  // received frame from the transport layer
  typedef struct packed {
    logic                 valid;
    logic [7:0]           fis_type;
    logic                 c_flag;
    logic [7:0]           devctl;
    dcl_cmd_class_e       cmd_class;
  } dcl_rx_frame_s;

  // frame request toward the transport layer
  typedef struct packed {
    logic                 valid;
    logic [7:0]           fis_type;
    logic                 i_flag;
    logic [7:0]           status;
    logic [7:0]           error;
    logic [4:0]           tag;
  } dcl_tx_req_s;

  // whole state of the controller
  typedef struct packed {
    dcl_state_e           state;
    logic [15:0]          diag_cnt;
    logic                 diag_fail;
    logic [7:0]           status;
    logic [7:0]           error;
    logic [31:0]          signature;
    dcl_tx_req_s          tx;
    dcl_proto_e           proto;
    logic                 proto_go;
    logic                 dma_setup_seen;
    logic                 abort_queue;
    logic                 hw_init;
    logic [31:0]          control;
    logic [31:0]          prdata;
    logic                 pready;
  } dcl_regs_s;
endpackage : dcl_pkg
`default_nettype wire
